// ==== core/ctim_pkg.sv ====
// Purpose: Shared constants for the composite PWM / pulse-width timer.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes:   Registers are 8 bits wide in the low byte of the word.
`default_nettype none

package ctim_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FC0 = 8'h00;
  localparam logic [7:0] OFS_FC1 = 8'h04;
  localparam logic [7:0] OFS_RS0 = 8'h08;
  localparam logic [7:0] OFS_RS1 = 8'h0C;
  localparam logic [7:0] OFS_OC = 8'h10;
  localparam logic [7:0] OFS_DT0 = 8'h14;
  localparam logic [7:0] OFS_DT1 = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RS_RUN = 7;
  localparam int RS_HO = 6;
  localparam int RS_IE = 5;
  localparam int RS_CAPF = 4;
  localparam int RS_BF = 3;
  localparam int RS_MF = 2;
  localparam int RS_SO = 1;
  localparam int RS_OE = 0;
  localparam int OC_TIS = 5;
  localparam int OC_MOD = 4;

  // ----------------------------------------------------------------
  // Function select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FN_FPWM = 4'h3;
  localparam logic [3:0] FN_VPWM = 4'h4;
  localparam logic [3:0] FN_PWC_H = 4'h8;
  localparam logic [3:0] FN_PWC_HC = 4'h9;
  localparam logic [3:0] FN_PWC_L = 4'hA;
  localparam logic [3:0] FN_PWC_CR = 4'hB;
  localparam logic [3:0] FN_PWC_CF = 4'hC;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [6:0] RST_PRE = 7'h00;
  localparam logic [15:0] TOP8 = 16'h00FF;
  localparam logic [15:0] TOP16 = 16'hFFFF;
  localparam logic [15:0] CNT_FPWM_START = 16'h0001;
  localparam int PRE_W = 7;

  typedef enum logic [1:0] {PH_IDLE, PH_MEAS, PH_CYC} phase_e;

endpackage : ctim_pkg

`default_nettype wire

// ==== core/ctim_sync.sv ====
// Purpose: Two-flop synchroniser for external pulse inputs.
// Assumes: Inputs are asynchronous to the machine clock.
// Notes:   First stage feeds only the second stage.
`default_nettype none

module ctim_sync #(
  parameter int W = 2
) (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_rst_n,
  // Data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (i_ce) begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule : ctim_sync

`default_nettype wire

// ==== core/ctim_tick.sv ====
// Purpose: Count-clock tick from the machine clock by a power of two.
// Assumes: Select value n divides the machine clock by 2**n.
// Notes:   Prescaler free-runs so both channels stay phase locked.
`default_nettype none

module ctim_tick (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_rst_n,
  input wire logic [2:0] i_sel,
  // Tick out
  output logic o_tick
);

  logic [ctim_pkg::PRE_W-1:0] pre_r;
  logic [ctim_pkg::PRE_W-1:0] mask;

  // ------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pre_r <= ctim_pkg::RST_PRE;
    end else if (i_ce) begin
      pre_r <= pre_r + 7'h01;
    end
  end

  // One tick per rising edge of the selected count clock
  assign mask = 7'((8'h01 << i_sel) - 8'h01);
  assign o_tick = ((pre_r & mask) == mask);

endmodule : ctim_tick

`default_nettype wire

// ==== core/ctim_top.sv ====
// Purpose: Dual 8-bit composite timer, PWM and pulse-width count modes.
// Assumes: APB slave, registers in the low byte, one answer wait state.
// Notes:   Joined mode uses channel 0 controls and a 16-bit count.
//
// Register access over APB and the register offsets were chosen for this implementation.
`default_nettype none

// Functional notes
// - Fixed PWM period is the full counter range, 8 or 16 bits.
// - Fixed PWM high time in count clocks comes from the data register.
// - Fixed PWM leaves match flag alone, starts the first period high and later periods high unless data is zero, ignores SO.
// - Data copied to compare latch at start, on match and at wrap; latch compared.
// - Stopping the timer holds the output at its last level.
// - First fixed PWM high pulse after start is one count clock shorter.
// - Variable PWM: channel 1 sets period, channel 0 low width, pin 0.
// - Variable PWM never joins the counters into 16 bits.
// - Variable PWM: setting either run bit clears the join bit.
// - Variable PWM starts its first period low, ignoring SO.
// - Variable PWM sets each channel match flag on its own match.
// - Low width above period keeps the variable PWM output low.
// - Data rewritten in variable PWM applies after next period match.
// - Pulse count clears and starts counting on the selected start edge.
// - End edge stores count and sets capture and buffer-full flags.
// - Reading the data register clears buffer-full.
// - Buffer-full blocks data overwrite, except the high width in high-and-period mode; that measurement is dropped.
// - High-and-period mode stores high width when full, not period.
// - Pulse count overflow sets match flag, toggles output from SO.
module ctim_top (
  // Clock, enable and reset
  input wire logic I_MCLK,
  input wire logic I_CE,
  input wire logic I_RSTN,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // External pulse inputs
  input wire logic I_EXT_IN0,
  input wire logic I_EXT_IN1,
  // Waveform pins
  output logic O_WAVE_PIN_TIMER0,
  output logic O_WAVE_PIN_TIMER1
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [3:0] fsel_r [2];
  logic [3:0] fsel_nxt [2];
  logic [2:0] ccs_r [2];
  logic [2:0] ccs_nxt [2];
  logic ife_r [2];
  logic ife_nxt [2];
  logic run_r [2];
  logic run_nxt [2];
  logic ho_r [2];
  logic ho_nxt [2];
  logic ie_r [2];
  logic ie_nxt [2];
  logic so_r [2];
  logic so_nxt [2];
  logic oe_r [2];
  logic oe_nxt [2];
  logic capf_r [2];
  logic capf_nxt [2];
  logic bf_r [2];
  logic bf_nxt [2];
  logic mf_r [2];
  logic mf_nxt [2];
  logic wave_r [2];
  logic wave_nxt [2];
  logic [7:0] cnt_r [2];
  logic [7:0] cnt_nxt [2];
  logic [7:0] lat_r [2];
  logic [7:0] lat_nxt [2];
  logic [7:0] data_r [2];
  logic [7:0] data_nxt [2];
  ctim_pkg::phase_e ph_r [2];
  ctim_pkg::phase_e ph_nxt [2];
  logic tis_r;
  logic tis_nxt;
  logic mod_r;
  logic mod_nxt;
  logic [3:0] flt_r;
  logic [3:0] flt_nxt;
  logic pin0_r;
  logic pin1_r;
  logic [1:0] ein_s;
  logic [1:0] ein_d_r;
  logic [1:0] rise;
  logic [1:0] fall;
  logic tick [2];
  logic sel_fc [2];
  logic sel_rs [2];
  logic sel_dt [2];
  logic sel_oc;
  logic hit;
  logic acc;
  logic wr;
  logic rd;
  logic start [2];
  logic vp;
  logic jn;
  logic [7:0] rmux;

  // ------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------
  ctim_sync #(.W(2)) u_sync (
    .i_clk(I_MCLK),
    .i_ce(I_CE),
    .i_rst_n(I_RSTN),
    .i_async({I_EXT_IN1, I_EXT_IN0}),
    .o_sync(ein_s)
  );

  for (genvar g = 0; g < 2; g++) begin : g_tick
    ctim_tick u_tick (
      .i_clk(I_MCLK),
      .i_ce(I_CE),
      .i_rst_n(I_RSTN),
      .i_sel(ccs_r[g]),
      .o_tick(tick[g])
    );
  end

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  assign sel_fc[0] = (I_PADDR == ctim_pkg::OFS_FC0);
  assign sel_fc[1] = (I_PADDR == ctim_pkg::OFS_FC1);
  assign sel_rs[0] = (I_PADDR == ctim_pkg::OFS_RS0);
  assign sel_rs[1] = (I_PADDR == ctim_pkg::OFS_RS1);
  assign sel_dt[0] = (I_PADDR == ctim_pkg::OFS_DT0);
  assign sel_dt[1] = (I_PADDR == ctim_pkg::OFS_DT1);
  assign sel_oc = (I_PADDR == ctim_pkg::OFS_OC);
  assign hit = sel_fc[0] | sel_fc[1] | sel_rs[0] | sel_rs[1] |
               sel_dt[0] | sel_dt[1] | sel_oc;
  // Writes and read side effects act only at the completing edge
  assign acc = I_PSEL & I_PENABLE & pready_r & hit;
  assign wr = acc & I_PWRITE;
  assign rd = acc & ~I_PWRITE;
  assign start[0] = wr & sel_rs[0] & I_PWDATA[ctim_pkg::RS_RUN] & ~run_r[0];
  assign start[1] = wr & sel_rs[1] & I_PWDATA[ctim_pkg::RS_RUN] & ~run_r[1];
  assign vp = (fsel_r[0] == ctim_pkg::FN_VPWM);
  assign jn = mod_r & ~vp;
  assign rise = ein_s & ~ein_d_r;
  assign fall = ~ein_s & ein_d_r;

  assign rmux =
    sel_fc[0] ? {ife_r[0], ccs_r[0], fsel_r[0]} :
    sel_fc[1] ? {ife_r[1], ccs_r[1], fsel_r[1]} :
    sel_rs[0] ? {run_r[0], ho_r[0], ie_r[0], capf_r[0], bf_r[0], mf_r[0],
                 so_r[0], oe_r[0]} :
    sel_rs[1] ? {run_r[1], ho_r[1], ie_r[1], capf_r[1], bf_r[1], mf_r[1],
                 so_r[1], oe_r[1]} :
    sel_oc ? {wave_r[1], wave_r[0], tis_r, mod_r, flt_r} :
    sel_dt[0] ? data_r[0] :
    sel_dt[1] ? data_r[1] : ctim_pkg::RST_REG8;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic [15:0] c;
    logic [15:0] l;
    logic [15:0] d;
    logic [15:0] nx;
    logic wide;
    logic wrap;
    logic st_e;
    logic en_e;
    logic cyc;
    logic pwc;
    logic keep;
    c = 16'h0000;
    l = 16'h0000;
    d = 16'h0000;
    nx = 16'h0000;
    wide = 1'b0;
    wrap = 1'b0;
    st_e = 1'b0;
    en_e = 1'b0;
    cyc = 1'b0;
    pwc = 1'b0;
    keep = 1'b0;
    tis_nxt = tis_r;
    mod_nxt = mod_r;
    flt_nxt = flt_r;
    for (int i = 0; i < 2; i++) begin
      fsel_nxt[i] = fsel_r[i];
      ccs_nxt[i] = ccs_r[i];
      ife_nxt[i] = ife_r[i];
      run_nxt[i] = run_r[i];
      ho_nxt[i] = ho_r[i];
      ie_nxt[i] = ie_r[i];
      so_nxt[i] = so_r[i];
      oe_nxt[i] = oe_r[i];
      capf_nxt[i] = capf_r[i];
      bf_nxt[i] = bf_r[i];
      mf_nxt[i] = mf_r[i];
      wave_nxt[i] = wave_r[i];
      cnt_nxt[i] = cnt_r[i];
      lat_nxt[i] = lat_r[i];
      data_nxt[i] = data_r[i];
      ph_nxt[i] = ph_r[i];
      // Software side first, so hardware events below win over clears
      if (wr & sel_fc[i]) begin
        {ife_nxt[i], ccs_nxt[i], fsel_nxt[i]} = I_PWDATA[7:0];
      end
      if (wr & sel_rs[i]) begin
        run_nxt[i] = I_PWDATA[ctim_pkg::RS_RUN];
        ho_nxt[i] = I_PWDATA[ctim_pkg::RS_HO];
        ie_nxt[i] = I_PWDATA[ctim_pkg::RS_IE];
        so_nxt[i] = I_PWDATA[ctim_pkg::RS_SO];
        oe_nxt[i] = I_PWDATA[ctim_pkg::RS_OE];
        if (!I_PWDATA[ctim_pkg::RS_CAPF]) begin
          capf_nxt[i] = 1'b0;
        end
        if (!I_PWDATA[ctim_pkg::RS_MF]) begin
          mf_nxt[i] = 1'b0;
        end
      end
      if (wr & sel_dt[i]) begin
        data_nxt[i] = I_PWDATA[7:0];
      end
      if (rd & sel_dt[i]) begin
        bf_nxt[i] = 1'b0;
      end
    end
    if (wr & sel_oc) begin
      tis_nxt = I_PWDATA[ctim_pkg::OC_TIS];
      mod_nxt = I_PWDATA[ctim_pkg::OC_MOD];
      flt_nxt = I_PWDATA[3:0];
    end

    if (vp) begin
      // Variable-cycle PWM on both counters, output on channel 0
      if (start[0] | start[1]) begin
        mod_nxt = 1'b0;
        cnt_nxt[0] = ctim_pkg::RST_REG8;
        cnt_nxt[1] = ctim_pkg::RST_REG8;
        lat_nxt[0] = data_r[0];
        lat_nxt[1] = data_r[1];
        wave_nxt[0] = 1'b0;
      end else if ((run_r[0] | run_r[1]) & tick[0]) begin
        // Channel 0 tick drives both; the selections must agree
        if (8'(cnt_r[0] + 8'h01) == lat_r[0]) begin
          mf_nxt[0] = 1'b1;
        end
        if (8'(cnt_r[1] + 8'h01) == lat_r[1]) begin
          // Period end wins over the width match
          mf_nxt[1] = 1'b1;
          cnt_nxt[0] = ctim_pkg::RST_REG8;
          cnt_nxt[1] = ctim_pkg::RST_REG8;
          wave_nxt[0] = 1'b0;
          lat_nxt[0] = data_r[0];
          lat_nxt[1] = data_r[1];
        end else begin
          cnt_nxt[0] = 8'(cnt_r[0] + 8'h01);
          cnt_nxt[1] = 8'(cnt_r[1] + 8'h01);
          if (8'(cnt_r[0] + 8'h01) == lat_r[0]) begin
            wave_nxt[0] = 1'b1;
          end
        end
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!(i == 1 && jn)) begin
          wide = (i == 0) && jn;
          c = wide ? {cnt_r[1], cnt_r[0]} : {8'h00, cnt_r[i]};
          l = wide ? {lat_r[1], lat_r[0]} : {8'h00, lat_r[i]};
          d = wide ? {data_r[1], data_r[0]} : {8'h00, data_r[i]};
          wrap = (c == (wide ? ctim_pkg::TOP16 : ctim_pkg::TOP8));
          nx = wrap ? 16'h0000 : 16'(c + 16'h0001);
          pwc = (fsel_r[i] >= ctim_pkg::FN_PWC_H) &&
                (fsel_r[i] <= ctim_pkg::FN_PWC_CF);
          cyc = (fsel_r[i] == ctim_pkg::FN_PWC_CR) ||
                (fsel_r[i] == ctim_pkg::FN_PWC_CF);
          st_e = ((fsel_r[i] == ctim_pkg::FN_PWC_L) ||
                  (fsel_r[i] == ctim_pkg::FN_PWC_CF)) ? fall[i] : rise[i];
          en_e = ((fsel_r[i] == ctim_pkg::FN_PWC_L) ||
                  (fsel_r[i] == ctim_pkg::FN_PWC_CR)) ? rise[i] : fall[i];
          if (start[i]) begin
            lat_nxt[i] = d[7:0];
            if (wide) begin
              lat_nxt[1] = d[15:8];
            end
            ph_nxt[i] = ctim_pkg::PH_IDLE;
            if (fsel_r[i] == ctim_pkg::FN_FPWM) begin
              // Count from one: first high pulse is one clock short
              cnt_nxt[i] = ctim_pkg::CNT_FPWM_START[7:0];
              if (wide) begin
                cnt_nxt[1] = ctim_pkg::CNT_FPWM_START[15:8];
              end
              wave_nxt[i] = 1'b1;
            end else if (pwc) begin
              wave_nxt[i] = so_nxt[i];
            end
          end else if (run_r[i] && fsel_r[i] == ctim_pkg::FN_FPWM) begin
            // Match flag is never touched in this mode
            if (tick[i]) begin
              nx = wrap ? 16'h0000 : 16'(c + 16'h0001);
              if (wrap) begin
                wave_nxt[i] = (d != 16'h0000);
                l = d;
              end else if (nx == l) begin
                wave_nxt[i] = 1'b0;
                l = d;
              end
              cnt_nxt[i] = nx[7:0];
              lat_nxt[i] = l[7:0];
              if (wide) begin
                cnt_nxt[1] = nx[15:8];
                lat_nxt[1] = l[15:8];
              end
            end
          end else if (run_r[i] && pwc) begin
            if (tick[i] && ph_r[i] != ctim_pkg::PH_IDLE) begin
              cnt_nxt[i] = nx[7:0];
              if (wide) begin
                cnt_nxt[1] = nx[15:8];
              end
              if (wrap) begin
                mf_nxt[i] = 1'b1;
                wave_nxt[i] = ~wave_r[i];
              end
            end
            keep = 1'b0;
            case (ph_r[i])
              ctim_pkg::PH_IDLE: begin
                if (st_e) begin
                  keep = 1'b1;
                  ph_nxt[i] = ctim_pkg::PH_MEAS;
                end
              end
              ctim_pkg::PH_MEAS: begin
                if (en_e) begin
                  // High width stored even when full in this mode
                  if (!bf_r[i] || fsel_r[i] == ctim_pkg::FN_PWC_HC) begin
                    data_nxt[i] = c[7:0];
                    if (wide) begin
                      data_nxt[1] = c[15:8];
                    end
                    capf_nxt[i] = 1'b1;
                    bf_nxt[i] = 1'b1;
                  end
                  if (fsel_r[i] == ctim_pkg::FN_PWC_HC) begin
                    ph_nxt[i] = ctim_pkg::PH_CYC;
                  end else if (cyc) begin
                    keep = 1'b1;
                  end else begin
                    ph_nxt[i] = ctim_pkg::PH_IDLE;
                  end
                end
              end
              ctim_pkg::PH_CYC: begin
                if (rise[i]) begin
                  // Period dropped while the high width is unread
                  if (!bf_r[i]) begin
                    data_nxt[i] = c[7:0];
                    if (wide) begin
                      data_nxt[1] = c[15:8];
                    end
                    capf_nxt[i] = 1'b1;
                    bf_nxt[i] = 1'b1;
                  end
                  keep = 1'b1;
                  ph_nxt[i] = ctim_pkg::PH_MEAS;
                end
              end
              default: begin
                ph_nxt[i] = ctim_pkg::PH_IDLE;
              end
            endcase
            if (keep) begin
              cnt_nxt[i] = ctim_pkg::RST_REG8;
              if (wide) begin
                cnt_nxt[1] = ctim_pkg::RST_REG8;
              end
            end
          end
          // Stopped channels keep wave and counter as they are
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (I_CE) begin
      pready_r <= I_PSEL & I_PENABLE & ~pready_r;
      pslverr_r <= I_PSEL & I_PENABLE & ~pready_r & ~hit;
      if (I_PSEL & I_PENABLE & ~pready_r) begin
        prdata_r <= {24'h000000, I_PWRITE ? ctim_pkg::RST_REG8 : rmux};
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      for (int i = 0; i < 2; i++) begin
        {ife_r[i], ccs_r[i], fsel_r[i]} <= ctim_pkg::RST_REG8;
        {run_r[i], ho_r[i], ie_r[i], capf_r[i]} <= 4'h0;
        {bf_r[i], mf_r[i], so_r[i], oe_r[i]} <= 4'h0;
        wave_r[i] <= 1'b0;
        cnt_r[i] <= ctim_pkg::RST_REG8;
        lat_r[i] <= ctim_pkg::RST_REG8;
        data_r[i] <= ctim_pkg::RST_REG8;
        ph_r[i] <= ctim_pkg::PH_IDLE;
      end
      {tis_r, mod_r} <= 2'h0;
      flt_r <= 4'h0;
      ein_d_r <= 2'h0;
      pin0_r <= 1'b0;
      pin1_r <= 1'b0;
    end else if (I_CE) begin
      for (int i = 0; i < 2; i++) begin
        {ife_r[i], ccs_r[i], fsel_r[i]} <=
          {ife_nxt[i], ccs_nxt[i], fsel_nxt[i]};
        {run_r[i], ho_r[i], ie_r[i], capf_r[i]} <=
          {run_nxt[i], ho_nxt[i], ie_nxt[i], capf_nxt[i]};
        {bf_r[i], mf_r[i], so_r[i], oe_r[i]} <=
          {bf_nxt[i], mf_nxt[i], so_nxt[i], oe_nxt[i]};
        wave_r[i] <= wave_nxt[i];
        cnt_r[i] <= cnt_nxt[i];
        lat_r[i] <= lat_nxt[i];
        data_r[i] <= data_nxt[i];
        ph_r[i] <= ph_nxt[i];
      end
      {tis_r, mod_r} <= {tis_nxt, mod_nxt};
      flt_r <= flt_nxt;
      ein_d_r <= ein_s;
      // Pins follow the wave level gated by each output enable
      pin0_r <= wave_nxt[0] & oe_nxt[0];
      pin1_r <= wave_nxt[1] & oe_nxt[1];
    end
  end

  assign O_PREADY = pready_r;
  assign O_PSLVERR = pslverr_r;
  assign O_PRDATA = prdata_r;
  assign O_WAVE_PIN_TIMER0 = pin0_r;
  assign O_WAVE_PIN_TIMER1 = pin1_r;

endmodule : ctim_top

`default_nettype wire

// ==== verification/ctim_top_sva.sv ====
// Purpose: Port checks for the composite timer
// Assumes: One clock, synchronous active-low reset
// Notes:   Sees only the top module ports
`default_nettype none
module ctim_top_sva (
  // Clock and control
  input wire logic I_MCLK,
  input wire logic I_CE,
  input wire logic I_RSTN,
  // APB
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // Pins
  input wire logic I_EXT_IN0,
  input wire logic I_EXT_IN1,
  input wire logic O_WAVE_PIN_TIMER0,
  input wire logic O_WAVE_PIN_TIMER1
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Checks
  // ------
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  wire acc = I_CE && I_PSEL && I_PENABLE;
  ready_wait_a: assert property (acc && !O_PREADY |=> O_PREADY)
    else $error("ready late");
  ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (O_PREADY |-> $past(acc))
    else $error("ready without access");
  err_ready_a: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  err_data_a: assert property (O_PSLVERR |-> O_PRDATA == 32'h0)
    else $error("error with data");
  rdata_upper_a: assert property (O_PREADY |-> O_PRDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  wave_reset_a: assert property (disable iff (1'b0)
    !I_RSTN |=> !O_WAVE_PIN_TIMER0 && !O_WAVE_PIN_TIMER1)
    else $error("pin high after reset");
  ce_hold_a: assert property (!I_CE |=> $stable(O_WAVE_PIN_TIMER0))
    else $error("pin moved while frozen");
  cover property (O_PREADY && O_PSLVERR);
  cover property ($rose(O_WAVE_PIN_TIMER0));
  cover property (!I_CE ##1 I_CE);
endmodule : ctim_top_sva
bind ctim_top ctim_top_sva u_ctim_top_sva (.I_MCLK, .I_CE, .I_RSTN,
  .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PRDATA,
  .O_PREADY, .O_PSLVERR, .I_EXT_IN0, .I_EXT_IN1, .O_WAVE_PIN_TIMER0,
  .O_WAVE_PIN_TIMER1);
`default_nettype wire

// ==== verification/ctim_pulse_src.sv ====
// Purpose: External pulse source for the measured input
// Assumes: Width counted in machine clocks
// Notes:   Idle low; one high pulse per request
`default_nettype none
module ctim_pulse_src (
  // Clock and request
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [15:0] i_width,
  // Pulse out
  output logic o_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  int left;
  initial begin
    o_pulse = 1'b0;
    left = 0;
  end
  always @(posedge i_clk) begin
    if (i_go && left == 0) begin
      o_pulse <= 1'b1;
      left <= int'(i_width);
    end else if (left > 1) begin
      left <= left - 1;
    end else if (left == 1) begin
      o_pulse <= 1'b0;
      left <= 0;
    end
  end
endmodule : ctim_pulse_src
`default_nettype wire

// ==== verification/tb_composite_timer_pwm_pwc.sv ====
// Purpose: Self-checking bench for the composite timer
// Assumes: Count clock select 0, one tick per machine clock
// Notes:   Pin widths are counted in machine clocks
`default_nettype none
module tb_composite_timer_pwm_pwc;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, ce, rstn, psel, pen, pwr, ext0, go, err;
  logic pready, pslverr, wave0, wave1;
  logic [7:0] paddr;
  logic [15:0] width;
  logic [31:0] pwdata, prdata, rd;
  int err_count, n_checks, h, l, w, p, bf;
  int unsigned seed;
  int exp_q[$];
  ctim_top u_ctim_top (.I_MCLK(mclk), .I_CE(ce), .I_RSTN(rstn),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_EXT_IN0(ext0), .I_EXT_IN1(ext0),
    .O_WAVE_PIN_TIMER0(wave0), .O_WAVE_PIN_TIMER1(wave1));
  ctim_pulse_src u_ctim_pulse_src (.i_clk(mclk), .i_go(go),
    .i_width(width), .o_pulse(ext0));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic int rnd(input int lo, input int span);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return lo + int'(seed % span);
  endfunction : rnd
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %0h got %0h", s, e, g);
    end
  endtask : chk
  task automatic chk_cnt(input string s, input int e, input int g);
    n_checks++;
    if (g != e) begin
      err_count++;
      $display("wrong value %s exp %0d got %0d", s, e, g);
    end
  endtask : chk_cnt
  // Pready, data and error are taken at the edge that sees ready high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic lvl(input logic v, output int n);
    n = 0;
    while (wave0 !== v && n < 3000) begin
      @(posedge mclk);
      n++;
    end
  endtask : lvl
  task automatic pulse(input int hw);
    width <= 16'(hw);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (hw + 12) @(posedge mclk);
    if (bf == 0) exp_q.push_back(hw);
    bf = 1;
  endtask : pulse
  // Capture may land one count short of the pulse width
  task automatic rdt();
    int e;
    int g;
    e = exp_q.pop_front();
    apb(1'b0, ctim_pkg::OFS_DT0, 32'h0);
    g = int'(rd[7:0]);
    chk_cnt("pwc width", e, (g + 1 == e) ? e : g);
    bf = 0;
  endtask : rdt
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    finish_test();
  end
  initial begin
    {seed, err_count, n_checks, bf} = {32'd16451, 96'h0};
    {rstn, ce, psel, pen, pwr, go} = 6'b010000;
    {paddr, pwdata, width} = 56'h0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    chk("pin reset", 32'h0, {30'h0, wave1, wave0});
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    w = rnd(40, 200);
    apb(1'b1, ctim_pkg::OFS_FC0, {28'h0, ctim_pkg::FN_FPWM});
    apb(1'b1, ctim_pkg::OFS_DT0, w);
    apb(1'b1, ctim_pkg::OFS_RS0, 32'h81);
    lvl(1'b0, h);
    lvl(1'b1, l);
    lvl(1'b0, p);
    chk_cnt("fixed high", w, p);
    chk_cnt("first high", w - 1, h);
    lvl(1'b1, l);
    chk_cnt("fixed period", 256, p + l);
    apb(1'b0, ctim_pkg::OFS_RS0, 32'h0);
    chk("match flag", 32'h0, {31'h0, rd[ctim_pkg::RS_MF]});
    apb(1'b1, ctim_pkg::OFS_RS0, 32'h01);
    lvl(1'b0, h);
    chk_cnt("stop hold", 3000, h);
    chk("stop level", 32'h1, {31'h0, wave0});
    p = rnd(70, 140);
    w = rnd(10, 40);
    apb(1'b1, ctim_pkg::OFS_FC1, {28'h0, ctim_pkg::FN_VPWM});
    apb(1'b1, ctim_pkg::OFS_FC0, {28'h0, ctim_pkg::FN_VPWM});
    apb(1'b1, ctim_pkg::OFS_DT0, w);
    apb(1'b1, ctim_pkg::OFS_DT1, p);
    apb(1'b1, ctim_pkg::OFS_OC, 32'h10);
    apb(1'b1, ctim_pkg::OFS_RS0, 32'h83);
    chk("start low", 32'h0, {31'h0, wave0});
    apb(1'b0, ctim_pkg::OFS_OC, 32'h0);
    chk("join bit", 32'h0, {31'h0, rd[ctim_pkg::OC_MOD]});
    lvl(1'b1, l);
    lvl(1'b0, h);
    lvl(1'b1, l);
    chk_cnt("var high", p - w, h);
    chk_cnt("var period", p, h + l);
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, 8'(ctim_pkg::OFS_RS0 + 8'(i * 4)), 32'h0);
      chk("var match", 32'h1, {31'h0, rd[ctim_pkg::RS_MF]});
    end
    apb(1'b1, ctim_pkg::OFS_DT0, w + 5);
    repeat (2) lvl(1'b0, h);
    lvl(1'b1, l);
    lvl(1'b0, h);
    chk_cnt("new low width", p - w - 5, h);
    ce <= 1'b0;
    repeat (4) @(posedge mclk);
    ce <= 1'b1;
    apb(1'b1, ctim_pkg::OFS_DT0, p + 10);
    lvl(1'b1, l);
    lvl(1'b0, h);
    lvl(1'b1, h);
    chk_cnt("never high", 3000, h);
    chk("low level", 32'h0, {31'h0, wave0});
    apb(1'b1, ctim_pkg::OFS_RS0, 32'h01);
    apb(1'b1, ctim_pkg::OFS_FC0, {28'h0, ctim_pkg::FN_PWC_H});
    apb(1'b1, ctim_pkg::OFS_RS0, 32'h83);
    chk("pwc init", 32'h1, {31'h0, wave0});
    pulse(rnd(10, 50));
    pulse(rnd(10, 50));
    apb(1'b0, ctim_pkg::OFS_RS0, 32'h0);
    chk("capture full", 32'h3, {30'h0, rd[4:3]});
    rdt();
    apb(1'b0, ctim_pkg::OFS_RS0, 32'h0);
    chk("full cleared", 32'h0, {31'h0, rd[ctim_pkg::RS_BF]});
    pulse(rnd(10, 50));
    rdt();
    finish_test();
  end
endmodule : tb_composite_timer_pwm_pwc
`default_nettype wire
